// *** hw/syn3w_pkg.sv ***
// package: constants for the three-wire synthesizer programming port
// assumes: a 50 MHz system clock and APB register access with 32-bit data
package syn3w_pkg;
  // serial word layout
  localparam int SYN3W_WORD_BITS = 16;
  localparam int SYN3W_ADDR_BITS = 4;
  localparam int SYN3W_DATA_BITS = 12;
  localparam int SYN3W_MOD_MIN = 2;
  localparam int SYN3W_MOD_MAX = 12;
  localparam int SYN3W_CNT_W = 5;
  localparam int SYN3W_NUM_REGS = 16;
  // APB byte offsets
  localparam logic [7:0] SYN3W_CTRL_OFF = 8'h00;
  localparam logic [7:0] SYN3W_STAT_OFF = 8'h04;
  localparam logic [7:0] SYN3W_MASK_OFF = 8'h08;
  localparam logic [7:0] SYN3W_LAST_OFF = 8'h0C;
  localparam logic [7:0] SYN3W_MOD_OFF = 8'h10;
  localparam logic [7:0] SYN3W_REGS_OFF = 8'h40;
  // control field positions
  localparam int SYN3W_CTRL_MUXSEL = 0;
  localparam int SYN3W_CTRL_MUXTRI = 3;
  localparam int SYN3W_CTRL_MSTEER = 4;
  localparam int SYN3W_CTRL_ASTEER = 5;
  localparam int SYN3W_CTRL_ADDIS = 6;
  localparam int SYN3W_CTRL_MODIN = 7;
  localparam logic [7:0] SYN3W_CTRL_RST = 8'h00;
  // status bit positions
  localparam int SYN3W_ST_DONE = 0;
  localparam int SYN3W_ST_LENERR = 1;
  localparam int SYN3W_ST_MUNLK = 2;
  localparam int SYN3W_ST_AUNLK = 3;
  localparam int SYN3W_ST_W = 4;
  // out-of-lock pulse timing
  localparam int SYN3W_CLK_MHZ = 50;
  localparam int SYN3W_LOCK_PERIOD_NS = 1000;
  localparam int SYN3W_LOCK_PERIOD_CYC = SYN3W_LOCK_PERIOD_NS * SYN3W_CLK_MHZ / 1000;
  // observation select codes
  typedef enum logic [2:0] {
    SYN3W_OBS_OSC = 3'b000,
    SYN3W_OBS_AUXREF = 3'b001,
    SYN3W_OBS_MAINREF = 3'b010,
    SYN3W_OBS_AUXPD = 3'b011,
    SYN3W_OBS_MAINPD = 3'b100,
    SYN3W_OBS_SERDATA = 3'b101,
    SYN3W_OBS_TEST = 3'b110,
    SYN3W_OBS_UNUSED = 3'b111
  } syn3w_obs_t;
endpackage

// *** hw/syn3w_sync.sv ***
// file: two-flop synchroniser for a vector of asynchronous levels
// assumes: each bit is an independent level from outside the clk domain
`timescale 1ns/1ps
module syn3w_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** hw/syn3w_prog_port.sv ***
// file: three-wire programming port, observation mux and lock pins
// assumes: serial pins and analog-side levels are asynchronous to clk;
// APB master on clk; open-collector pins resolved outside
`timescale 1ns/1ps
// Summary of operation
// - sample data on clock rise, address first
// - load enable rise commits data to address
// - clock edges ignored while load enable high
// - modulation input pin may replace data pin
// - out-of-lock low pulses, else high impedance
// - lock pin becomes steering output when configured
// - observation output shows one selected signal
// - observation output can be tri-stated
// - addressed transfers are exactly sixteen bits
// - address-free samples two to twelve bits
// - three-bit select code picks observation source
// - tri-state bit set means pin undriven
module syn3w_prog_port
  import syn3w_pkg::*;
#(
  parameter int LOCK_PERIOD = SYN3W_LOCK_PERIOD_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic serClk,
  input wire logic serData,
  input wire logic modIn,
  input wire logic loadEn_n,
  input wire logic oscRef,
  input wire logic auxRef,
  input wire logic mainRef,
  input wire logic auxPd,
  input wire logic mainPd,
  input wire logic mainLocked,
  input wire logic auxLocked,
  input wire logic mainSteerLevel,
  input wire logic auxSteerLevel,
  output logic obsOut,
  output logic obsOe,
  output logic main_lock_steer_pin_out,
  output logic main_lock_steer_pin_oe,
  output logic aux_lock_steer_pin_out,
  output logic aux_lock_steer_pin_oe
);
  // ==========================================================
  // input synchronisation
  localparam int NSYNC = 13;
  // idle levels: load enable high, both loops locked, so no false event follows reset
  localparam logic [NSYNC-1:0] SYNC_RST = 13'h0608;
  logic [NSYNC-1:0] syncIn;
  logic [NSYNC-1:0] syncOut;
  logic sclkS, dataS, modS, csS;
  logic [4:0] obsSrc;
  logic [1:0] lockedS, steerS;

  assign syncIn = {auxSteerLevel, mainSteerLevel, auxLocked, mainLocked,
                   mainPd, auxPd, mainRef, auxRef, oscRef,
                   loadEn_n, modIn, serData, serClk};
  syn3w_sync #(.W(NSYNC), .RST_VAL(SYNC_RST)) u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .d(syncIn),
    .q(syncOut)
  );
  assign sclkS = syncOut[0];
  assign dataS = syncOut[1];
  assign modS = syncOut[2];
  assign csS = syncOut[3];
  assign obsSrc = syncOut[8:4];
  assign lockedS = syncOut[10:9];
  assign steerS = syncOut[12:11];

  // ==========================================================
  // control and status registers
  logic [7:0] ctrl;
  logic [SYN3W_ST_W-1:0] status;
  logic [SYN3W_ST_W-1:0] mask;
  logic [SYN3W_ST_W-1:0] evt;
  logic [SYN3W_ADDR_BITS-1:0] lastAddr;
  logic [SYN3W_CNT_W-1:0] lastLen;
  logic [SYN3W_DATA_BITS-1:0] modData;
  logic [SYN3W_DATA_BITS-1:0] regs [SYN3W_NUM_REGS];
  logic apbWr;
  logic stsWr;
  logic [2:0] muxSel;
  logic muxTri, modAddrDis, useModIn;
  logic [1:0] steerMode;

  assign apbWr = psel && penable && pwrite;
  assign stsWr = apbWr && (paddr == SYN3W_STAT_OFF);
  assign muxSel = ctrl[SYN3W_CTRL_MUXSEL +: 3];
  assign muxTri = ctrl[SYN3W_CTRL_MUXTRI];
  assign steerMode = {ctrl[SYN3W_CTRL_ASTEER], ctrl[SYN3W_CTRL_MSTEER]};
  assign modAddrDis = ctrl[SYN3W_CTRL_ADDIS];
  assign useModIn = ctrl[SYN3W_CTRL_MODIN];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= SYN3W_CTRL_RST;
      mask <= '0;
    end
    else if (apbWr && paddr == SYN3W_CTRL_OFF)
      ctrl <= pwdata[7:0];
    else if (apbWr && paddr == SYN3W_MASK_OFF)
      mask <= pwdata[SYN3W_ST_W-1:0];
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= '0;
    else
      status <= (status & ~(stsWr ? pwdata[SYN3W_ST_W-1:0] : '0)) | evt;
  end

  assign irq = |(status & mask);

  // ==========================================================
  // APB read side: zero wait states, error on unmapped offsets
  logic regHit;
  logic [SYN3W_ADDR_BITS-1:0] regIdx;

  assign regHit = (paddr[7:6] == SYN3W_REGS_OFF[7:6]) && (paddr[1:0] == 2'b00);
  assign regIdx = paddr[5:2];
  assign pready = 1'b1;

  always_comb
  begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable)
    begin
      if (paddr == SYN3W_CTRL_OFF)
        prdata = {24'h00_0000, ctrl};
      else if (paddr == SYN3W_STAT_OFF)
        prdata = {28'h000_0000, status};
      else if (paddr == SYN3W_MASK_OFF)
        prdata = {28'h000_0000, mask};
      else if (paddr == SYN3W_LAST_OFF)
        prdata = {23'h00_0000, lastLen, lastAddr};
      else if (paddr == SYN3W_MOD_OFF)
        prdata = {20'h0_0000, modData};
      else if (regHit && !pwrite)
        prdata = {20'h0_0000, regs[regIdx]};
      else
        pslverr = 1'b1;
    end
  end

  // ==========================================================
  // serial shifter
  logic sclkPrev, csPrev;
  logic sclkRise, csRise;
  logic inBit;
  logic [SYN3W_WORD_BITS-1:0] shiftReg;
  logic [SYN3W_CNT_W-1:0] bitCnt;
  logic wordOk, modOk, lenErr;
  logic [SYN3W_ADDR_BITS-1:0] wordAddr;
  logic [SYN3W_DATA_BITS-1:0] wordData;

  assign sclkRise = sclkS && !sclkPrev;
  assign csRise = csS && !csPrev;
  assign inBit = useModIn ? modS : dataS;
  assign wordAddr = shiftReg[SYN3W_WORD_BITS-1 -: SYN3W_ADDR_BITS];
  assign wordData = shiftReg[SYN3W_DATA_BITS-1:0];
  assign wordOk = !modAddrDis && bitCnt == SYN3W_CNT_W'(SYN3W_WORD_BITS);
  assign modOk = modAddrDis && bitCnt >= SYN3W_CNT_W'(SYN3W_MOD_MIN)
                 && bitCnt <= SYN3W_CNT_W'(SYN3W_MOD_MAX);
  assign lenErr = csRise && !wordOk && !modOk;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclkPrev <= 1'b0;
      csPrev <= 1'b1;
    end
    else
    begin
      sclkPrev <= sclkS;
      csPrev <= csS;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftReg <= '0;
      bitCnt <= '0;
    end
    else if (csS && !csPrev)
      bitCnt <= '0;
    else if (!csS && sclkRise)
    begin
      shiftReg <= {shiftReg[SYN3W_WORD_BITS-2:0], inBit};
      if (bitCnt != '1)
        bitCnt <= bitCnt + 1'b1;
    end
  end

  // only a complete transfer reaches the register bank
  always_ff @(posedge clk)
  begin
    if (csRise && wordOk)
      regs[wordAddr] <= wordData;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modData <= '0;
      lastAddr <= '0;
      lastLen <= '0;
    end
    else if (csRise && wordOk)
    begin
      lastAddr <= wordAddr;
      lastLen <= bitCnt;
    end
    else if (csRise && modOk)
    begin
      modData <= wordData & SYN3W_DATA_BITS'((32'h1 << bitCnt) - 1);
      lastLen <= bitCnt;
    end
  end

  // ==========================================================
  // lock / steering pins
  logic [$clog2(LOCK_PERIOD+1)-1:0] divCnt;
  logic lockTick;
  logic [1:0] lockedPrev;
  logic [1:0] pinOut, pinOe;

  assign lockTick = divCnt == '0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      divCnt <= '0;
    else if (lockTick)
      divCnt <= ($clog2(LOCK_PERIOD+1))'(LOCK_PERIOD - 1);
    else
      divCnt <= divCnt - 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinOut <= '0;
      pinOe <= '0;
      lockedPrev <= '1;
    end
    else
    begin
      lockedPrev <= lockedS;
      for (int i = 0; i < 2; i++)
      begin
        if (steerMode[i])
        begin
          pinOut[i] <= steerS[i];
          pinOe[i] <= 1'b1;
        end
        else
        begin
          pinOut[i] <= 1'b0;
          pinOe[i] <= !lockedS[i] && lockTick;
        end
      end
    end
  end

  assign main_lock_steer_pin_out = pinOut[0];
  assign main_lock_steer_pin_oe = pinOe[0];
  assign aux_lock_steer_pin_out = pinOut[1];
  assign aux_lock_steer_pin_oe = pinOe[1];

  assign evt = {lockedPrev[1] && !lockedS[1], lockedPrev[0] && !lockedS[0],
                lenErr, csRise && (wordOk || modOk)};

  // ==========================================================
  // observation output
  logic obsNext;
  logic serLoop;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      serLoop <= 1'b0;
    else if (!csS && sclkRise)
      serLoop <= shiftReg[SYN3W_WORD_BITS-1];
  end

  always_comb
  begin
    unique case (syn3w_obs_t'(muxSel))
      SYN3W_OBS_OSC: obsNext = obsSrc[0];
      SYN3W_OBS_AUXREF: obsNext = obsSrc[1];
      SYN3W_OBS_MAINREF: obsNext = obsSrc[2];
      SYN3W_OBS_AUXPD: obsNext = obsSrc[3];
      SYN3W_OBS_MAINPD: obsNext = obsSrc[4];
      SYN3W_OBS_SERDATA: obsNext = serLoop;
      SYN3W_OBS_TEST: obsNext = !csS;
      SYN3W_OBS_UNUSED: obsNext = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      obsOut <= 1'b0;
      obsOe <= 1'b0;
    end
    else
    begin
      obsOut <= obsNext;
      obsOe <= !muxTri;
    end
  end

  // ==========================================================
  // assertions
  sequence shiftEdge_s;
    !csS && sclkRise && bitCnt != '1;
  endsequence

  sequence goodEnd_s;
    csRise && wordOk;
  endsequence

  shift_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    shiftEdge_s |=> bitCnt == $past(bitCnt) + 1'b1 && shiftReg[0] == $past(inBit))
    else $error("bit count or sampled bit wrong on clock edge");

  ignore_high_a: assert property (@(posedge clk) disable iff (!arst_n)
    csS && $past(csS) |=> $stable(shiftReg) && bitCnt == '0)
    else $error("shift activity while load enable high");

  commit_word_a: assert property (@(posedge clk) disable iff (!arst_n)
    goodEnd_s |=> regs[$past(wordAddr)] == $past(wordData) && status[SYN3W_ST_DONE])
    else $error("register not committed on load enable rise");

  len_error_a: assert property (@(posedge clk) disable iff (!arst_n)
    csRise && !modAddrDis && bitCnt != SYN3W_CNT_W'(SYN3W_WORD_BITS)
    |=> status[SYN3W_ST_LENERR] && lastLen == $past(lastLen))
    else $error("short addressed transfer not flagged");

  mod_sample_a: assert property (@(posedge clk) disable iff (!arst_n)
    csRise && modOk |=> lastLen == $past(bitCnt) && status[SYN3W_ST_DONE])
    else $error("modulation sample not captured");

  no_partial_a: assert property (@(posedge clk) disable iff (!arst_n)
    !csRise ##1 !csRise |-> $stable(lastAddr))
    else $error("commit without load enable rise");

  lock_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
    !steerMode[0] && lockedS[0] |=> !pinOe[0])
    else $error("main lock pin driven while locked");

  steer_a: assert property (@(posedge clk) disable iff (!arst_n)
    steerMode[1] |=> pinOe[1] && pinOut[1] == $past(steerS[1]))
    else $error("aux steering output wrong");

  obs_tri_a: assert property (@(posedge clk) disable iff (!arst_n)
    muxTri [*2] |-> !obsOe)
    else $error("observation pin driven while tri-stated");

  obs_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
    muxSel == 3'b111 |=> !obsOut)
    else $error("unused select code not low");
endmodule

// *** test/syn3w_host_model.sv ***
// host controller model driving the three-wire serial programming link
// assumes: called from the bench; link clock period is 160 ns
`timescale 1ns/1ps
module syn3w_host_model
(
  output logic serClk,
  output logic serData,
  output logic modIn,
  output logic loadEn_n
);
  initial
  begin
    serClk = 1'b0;
    serData = 1'b0;
    modIn = 1'b1;
    loadEn_n = 1'b1;
  end
  // ==========================================================
  // frame: msb first, data changes while the link clock is low
  task automatic send(input logic [15:0] w, input int n, input bit useMod);
    #7;
    loadEn_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #80 serClk = 1'b0;
      // frames longer than a word repeat its low bits, never an undriven bit
      serData = useMod ? ~w[i % 16] : w[i % 16];
      modIn = useMod ? w[i % 16] : ~w[i % 16];
      #80 serClk = 1'b1;
    end
    #80 serClk = 1'b0;
    #80 loadEn_n = 1'b1;
    // released lines no longer show the last bit
    serData = ~serData;
    modIn = ~modIn;
    #400;
  endtask
  // stray link clocks outside any frame
  task automatic stray(input int n);
    #7;
    repeat (n)
    begin
      #80 serClk = 1'b1;
      #80 serClk = 1'b0;
    end
  endtask
endmodule

// *** test/three_wire_synth_prog_port_tb.sv ***
// self-checking bench for the programming port
// assumes: syn3w_pkg compiled first; apb answers with no wait states
`timescale 1ns/1ps
module three_wire_synth_prog_port_tb;
  import syn3w_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, obsOut, obsOe, mOut, mOe, aOut, aOe, err;
  logic [4:0] src = '0;
  logic mainLocked = 1, auxLocked = 1, mSteer = 0, aSteer = 0;
  wire serClk, serData, modIn, loadEn_n;
  logic [3:0] a;
  logic [11:0] d;
  int miscompares = 0, n_tests = 0, cyc = 0, c, n;
  always #10 clk = ~clk;
  syn3w_host_model host (.serClk(serClk), .serData(serData), .modIn(modIn),
    .loadEn_n(loadEn_n));
  syn3w_prog_port #(.LOCK_PERIOD(4)) uut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .serClk(serClk), .serData(serData),
    .modIn(modIn), .loadEn_n(loadEn_n), .oscRef(src[0]), .auxRef(src[1]),
    .mainRef(src[2]), .auxPd(src[3]), .mainPd(src[4]), .mainLocked(mainLocked),
    .auxLocked(auxLocked), .mainSteerLevel(mSteer), .auxSteerLevel(aSteer),
    .obsOut(obsOut), .obsOe(obsOe), .main_lock_steer_pin_out(mOut),
    .main_lock_steer_pin_oe(mOe), .aux_lock_steer_pin_out(aOut),
    .aux_lock_steer_pin_oe(aOe));
  // ==========================================================
  task automatic summarize;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    // ends once pready is seen high; if it never rises, only the bench timeout ends this wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] lastExp(input logic [3:0] ad, input int len);
    return {23'h0, len[4:0], ad};
  endfunction
  // loop-back shows the last bit of the word sent before the latest one
  function automatic logic obsExp(input int code);
    return code < 5 ? src[code] : code == 5;
  endfunction
  task automatic xfer(input logic [15:0] w, input int len, input bit useMod);
    host.send(w, len, useMod);
    repeat (6) @(posedge clk);
  endtask
  task automatic lockCount(output int cnt);
    cnt = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      cnt += (mOe === 1'b1 && mOut === 1'b0);
    end
  endtask
  // ==========================================================
  initial
  begin
    rd = $urandom(32'hc4ea);
    repeat (12) @(posedge clk);
    arst_n <= 1;
    repeat (4) @(posedge clk);
    apb(0, SYN3W_CTRL_OFF, 0);
    chk(rd, 0);
    chk({irq, mOe, aOe}, 0);
    chk(err, 0);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      a = i == 0 ? 4'h0 : (i == 7 ? 4'hf : 4'($urandom));
      d = i == 0 ? 12'hfff : (i == 7 ? 12'h000 : 12'($urandom));
      xfer({a, d}, 16, 0);
      apb(0, SYN3W_REGS_OFF + {a, 2'b00}, 0);
      chk(rd, {20'h0, d});
      apb(0, SYN3W_LAST_OFF, 0);
      chk(rd, lastExp(a, 16));
      apb(0, SYN3W_STAT_OFF, 0);
      chk(rd & 32'h3, 32'h1);
    end
    $display("addressed write test done");
    // the bank is loaded only from the serial link
    apb(1, SYN3W_REGS_OFF + {a, 2'b00}, 32'h5a5);
    chk(err, 1);
    apb(1, SYN3W_MASK_OFF, 32'h1);
    chk(irq, 1);
    apb(1, SYN3W_STAT_OFF, 32'h1);
    chk({irq, rd[0]}, 2'b01);
    for (int k = 0; k < 2; k++)
    begin
      xfer({a, ~d}, k ? 17 : 15, 0);
      apb(0, SYN3W_REGS_OFF + {a, 2'b00}, 0);
      chk(rd, {20'h0, d});
      apb(0, SYN3W_STAT_OFF, 0);
      chk(rd & 32'h3, 32'h2);
      apb(1, SYN3W_STAT_OFF, 32'h3);
    end
    apb(1, SYN3W_MASK_OFF, 32'h0);
    host.stray(5);
    repeat (6) @(posedge clk);
    apb(0, SYN3W_STAT_OFF, 0);
    chk(rd & 32'h3, 0);
    xfer({~a, d}, 16, 0);
    apb(0, SYN3W_REGS_OFF + {~a, 2'b00}, 0);
    chk(rd, {20'h0, d});
    $display("error and abort test done");
    apb(1, SYN3W_CTRL_OFF, 32'hc0);
    for (int k = 0; k < 6; k++)
    begin
      n = k == 0 ? 2 : (k == 1 ? 12 : (k == 2 ? 13 : 2 + $urandom % 11));
      d = 12'($urandom);
      apb(1, SYN3W_STAT_OFF, 32'h3);
      xfer({4'h0, d}, n, 1);
      apb(0, SYN3W_STAT_OFF, 0);
      chk(rd & 32'h3, n > 12 ? 32'h2 : 32'h1);
      if (n <= 12)
      begin
        apb(0, SYN3W_MOD_OFF, 0);
        chk(rd, {20'h0, d & 12'((1 << n) - 1)});
      end
    end
    $display("modulation test done");
    for (int code = 0; code < 8; code++)
    begin
      src <= 5'($urandom);
      apb(1, SYN3W_CTRL_OFF, code);
      if (code == 5)
      begin
        xfer(16'h3001, 16, 0);
        xfer(16'h3000, 16, 0);
      end
      repeat (6) @(posedge clk);
      chk({obsOe, obsOut}, {1'b1, obsExp(code)});
      apb(1, SYN3W_CTRL_OFF, code | 8);
      repeat (2) @(posedge clk);
      chk(obsOe, 0);
    end
    $display("observation test done");
    apb(1, SYN3W_CTRL_OFF, 0);
    apb(1, SYN3W_STAT_OFF, 32'hf);
    apb(0, SYN3W_STAT_OFF, 0);
    chk(rd[SYN3W_ST_MUNLK], 0);
    mainLocked <= 0;
    repeat (6) @(posedge clk);
    lockCount(c);
    chk(c, 4);
    apb(0, SYN3W_STAT_OFF, 0);
    chk(rd[SYN3W_ST_MUNLK], 1);
    mainLocked <= 1;
    repeat (6) @(posedge clk);
    lockCount(c);
    chk(c, 0);
    mSteer <= 1;
    aSteer <= 1;
    apb(1, SYN3W_CTRL_OFF, 32'h30);
    repeat (6) @(posedge clk);
    chk({mOe, mOut, aOe, aOut}, 4'hf);
    mSteer <= 0;
    repeat (6) @(posedge clk);
    chk({mOe, mOut, aOe, aOut}, 4'hb);
    $display("lock pin test done");
    summarize();
  end
endmodule
